//--- logic/itrl_pkg.sv
package itrl_pkg;
  localparam int         NUM_CNT     = 3;
  localparam int         BYTE_W      = 8;
  localparam int         MODE_W      = 3;
  localparam int         ADDR_LSB    = 2;
  localparam logic [7:0] IDX_CNT0    = 8'h40;
  localparam logic [7:0] IDX_CNT1    = 8'h41;
  localparam logic [7:0] IDX_CNT2    = 8'h42;
  localparam logic [7:0] IDX_CTRL    = 8'h43;
  localparam logic [2:0] SEL_CTRL    = 3'h3;
  localparam logic [2:0] SEL_NONE    = 3'h4;
  localparam logic [1:0] SC_READBACK = 2'h3;
  localparam logic [1:0] FMT_LATCH   = 2'h0;
  localparam logic [1:0] FMT_LSB     = 2'h1;
  localparam logic [1:0] FMT_MSB     = 2'h2;
  localparam logic [1:0] FMT_WORD    = 2'h3;
  localparam int         CW_SC_LSB   = 6;
  localparam int         CW_RW_LSB   = 4;
  localparam int         CW_MODE_LSB = 1;
  localparam int         CW_BCD      = 0;
  localparam int         RB_COUNT_N  = 5;
  localparam int         RB_STATUS_N = 4;
  localparam int         RB_SEL_LSB  = 1;
  localparam int         ST_OUT      = 7;
  localparam int         ST_NULL     = 6;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [2:0] MODE_RST    = 3'h0;
  localparam logic [1:0] FMT_RST     = FMT_LSB;

  typedef enum logic {SEQ_LOW, SEQ_HIGH} itrl_seq_type;
endpackage

//--- logic/itrl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module itrl_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage feeds only the second
  always_comb
  begin
    stage1_next = d;
    sync_next   = stage1_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      stage1_reg <= '0;
      sync_reg   <= '0;
    end
    else
    begin
      stage1_reg <= stage1_next;
      sync_reg   <= sync_next;
    end
  end

  assign q = sync_reg;
endmodule
`default_nettype wire

//--- logic/itrl_count_elem.sv
`timescale 1ns/1ps
`default_nettype none
module itrl_count_elem #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output logic      [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // decrements every clock, takes a new initial count on load
  always_comb
  begin
    if (load)
      count_next = load_val;
    else
      count_next = count_reg - WIDTH'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign count = count_reg;
endmodule
`default_nettype wire

//--- logic/itrl_readout_latch.sv
`timescale 1ns/1ps
`default_nettype none
module itrl_readout_latch #(
  parameter int AW = 12,
  parameter int CW = 16
) (
  input  wire logic                         CLK,
  input  wire logic                         RESETN,
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [AW-1:0]                PADDR,
  input  wire logic [31:0]                  PWDATA,
  input  wire logic [itrl_pkg::NUM_CNT-1:0] COUNTER_OUT,
  output logic      [31:0]                  PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR
);
  import itrl_pkg::*;

  localparam int N = NUM_CNT;
  // byte address to target: counter index, control port or unmapped
  function automatic logic [2:0] decode(input logic [AW-1:0] addr);
    logic [AW-1:0] idx;
    idx = addr >> ADDR_LSB;
    if (addr[ADDR_LSB-1:0] != '0)
      return SEL_NONE;
    if (idx >= AW'(IDX_CNT0) && idx <= AW'(IDX_CTRL))
      return 3'(idx - AW'(IDX_CNT0));
    return SEL_NONE;
  endfunction
  // byte presented on a counter read
  function automatic logic [7:0] read_byte(
    input logic         st_held,
    input logic [7:0]   st,
    input logic         sn_held,
    input logic [CW-1:0] sn,
    input logic [CW-1:0] live,
    input logic [1:0]   fmt,
    input itrl_seq_type seq
  );
    logic [CW-1:0] src;
    src = sn_held ? sn : live;
    if (st_held)
      return st;
    case (fmt)
      FMT_MSB:  return src[BYTE_W +: BYTE_W];
      FMT_WORD: return (seq == SEQ_HIGH) ? src[BYTE_W +: BYTE_W] : src[0 +: BYTE_W];
      default:  return src[0 +: BYTE_W];
    endcase
  endfunction

  logic [31:0]  prdata_reg;
  logic [31:0]  prdata_next;
  logic         pready_reg;
  logic         pready_next;
  logic         pslverr_reg;
  logic         pslverr_next;

  logic [1:0]   fmt_reg       [N];
  logic [1:0]   fmt_next      [N];
  logic [2:0]   mode_reg      [N];
  logic [2:0]   mode_next     [N];
  logic         bcd_reg       [N];
  logic         bcd_next      [N];
  logic [CW-1:0] snap_reg     [N];
  logic [CW-1:0] snap_next    [N];
  logic         snap_held_reg [N];
  logic         snap_held_next[N];
  logic [7:0]   stat_reg      [N];
  logic [7:0]   stat_next     [N];
  logic         stat_held_reg [N];
  logic         stat_held_next[N];
  itrl_seq_type rd_seq_reg    [N];
  itrl_seq_type rd_seq_next   [N];
  itrl_seq_type wr_seq_reg    [N];
  itrl_seq_type wr_seq_next   [N];
  logic [7:0]   wr_low_reg    [N];
  logic [7:0]   wr_low_next   [N];
  logic         load_reg      [N];
  logic         load_next     [N];
  logic [CW-1:0] load_val_reg [N];
  logic [CW-1:0] load_val_next[N];
  logic         null_reg      [N];
  logic         null_next     [N];
  logic [CW-1:0] ce_count     [N];

  logic [N-1:0] out_sync;
  logic [7:0]   wbyte;
  logic [1:0]   w_sc;
  logic [1:0]   w_rw;
  logic [2:0]   sel_now;
  logic [1:0]   k;
  logic         access_first;
  logic         wr_done;
  logic         rd_done;
  logic         ctrl_wr;
  logic [N-1:0] rd_vec;
  logic [N-1:0] wr_vec;
  logic [N-1:0] prog_vec;
  logic [N-1:0] cap_cnt_vec;
  logic [N-1:0] cap_st_vec;

  itrl_sync #(
    .WIDTH (N)
  ) u_out_sync (
    .clk    (CLK),
    .resetn (RESETN),
    .d      (COUNTER_OUT),
    .q      (out_sync)
  );

  for (genvar g = 0; g < N; g++)
  begin : g_ce
    // one counting element per counter, never touched by captures
    itrl_count_elem #(
      .WIDTH (CW)
    ) u_ce (
      .clk      (CLK),
      .resetn   (RESETN),
      .load     (load_reg[g]),
      .load_val (load_val_reg[g]),
      .count    (ce_count[g])
    );
  end

  assign wbyte        = PWDATA[BYTE_W-1:0];
  assign w_sc         = wbyte[CW_SC_LSB +: 2];
  assign w_rw         = wbyte[CW_RW_LSB +: 2];
  assign sel_now      = decode(PADDR);
  assign k            = sel_now[1:0];
  assign access_first = PSEL & PENABLE & ~pready_reg;
  assign wr_done      = PSEL & PENABLE & pready_reg & PWRITE;
  assign rd_done      = PSEL & PENABLE & pready_reg & ~PWRITE;
  assign ctrl_wr      = wr_done & (sel_now == SEL_CTRL);

  // per-counter events of the completing transfer
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      rd_vec[i]      = rd_done & (sel_now == 3'(i));
      wr_vec[i]      = wr_done & (sel_now == 3'(i));
      prog_vec[i]    = ctrl_wr & (w_sc == 2'(i)) & (w_rw != FMT_LATCH);
      cap_cnt_vec[i] = ctrl_wr & (((w_sc == 2'(i)) & (w_rw == FMT_LATCH))
                     | ((w_sc == SC_READBACK) & ~wbyte[RB_COUNT_N]
                     & wbyte[RB_SEL_LSB + i]));
      cap_st_vec[i]  = ctrl_wr & (w_sc == SC_READBACK) & ~wbyte[RB_STATUS_N]
                     & wbyte[RB_SEL_LSB + i];
    end
  end

  // apb answer: one wait cycle, data and error prepared in the first access cycle
  always_comb
  begin
    pready_next  = access_first;
    pslverr_next = 1'b0;
    prdata_next  = prdata_reg;
    if (access_first)
    begin
      pslverr_next = (sel_now == SEL_NONE) | ((sel_now == SEL_CTRL) & ~PWRITE);
      prdata_next  = '0;
      if (!PWRITE && sel_now < SEL_CTRL)
        prdata_next = 32'(read_byte(stat_held_reg[k], stat_reg[k], snap_held_reg[k],
                                    snap_reg[k], ce_count[k], fmt_reg[k], rd_seq_reg[k]));
    end
  end

  // counter programming, captures and byte sequencing
  always_comb
  begin
    fmt_next       = fmt_reg;
    mode_next      = mode_reg;
    bcd_next       = bcd_reg;
    snap_next      = snap_reg;
    snap_held_next = snap_held_reg;
    stat_next      = stat_reg;
    stat_held_next = stat_held_reg;
    rd_seq_next    = rd_seq_reg;
    wr_seq_next    = wr_seq_reg;
    wr_low_next    = wr_low_reg;
    load_val_next  = load_val_reg;
    null_next      = null_reg;
    for (int i = 0; i < N; i++)
    begin
      load_next[i] = 1'b0;
      if (load_reg[i])
        null_next[i] = 1'b0;
      if (prog_vec[i])
      begin
        fmt_next[i]       = w_rw;
        mode_next[i]      = wbyte[CW_MODE_LSB +: MODE_W];
        bcd_next[i]       = wbyte[CW_BCD];
        snap_held_next[i] = 1'b0;
        stat_held_next[i] = 1'b0;
        rd_seq_next[i]    = SEQ_LOW;
        wr_seq_next[i]    = SEQ_LOW;
        null_next[i]      = 1'b1;
      end
      if (cap_cnt_vec[i] && !snap_held_reg[i])
      begin
        snap_next[i]      = ce_count[i];
        snap_held_next[i] = 1'b1;
      end
      if (cap_st_vec[i] && !stat_held_reg[i])
      begin
        stat_next[i]      = {out_sync[i], null_reg[i], fmt_reg[i], mode_reg[i], bcd_reg[i]};
        stat_held_next[i] = 1'b1;
      end
      if (rd_vec[i])
      begin
        if (stat_held_reg[i])
          stat_held_next[i] = 1'b0;
        else if (fmt_reg[i] == FMT_WORD && rd_seq_reg[i] == SEQ_LOW)
          rd_seq_next[i] = SEQ_HIGH;
        else
        begin
          rd_seq_next[i]    = SEQ_LOW;
          snap_held_next[i] = 1'b0;
        end
      end
      if (wr_vec[i])
      begin
        case (fmt_reg[i])
          FMT_MSB:
          begin
            load_val_next[i] = {wbyte, ZERO_BYTE};
            load_next[i]     = 1'b1;
          end
          FMT_WORD:
          begin
            if (wr_seq_reg[i] == SEQ_LOW)
            begin
              wr_low_next[i] = wbyte;
              wr_seq_next[i] = SEQ_HIGH;
            end
            else
            begin
              load_val_next[i] = {wbyte, wr_low_reg[i]};
              load_next[i]     = 1'b1;
              wr_seq_next[i]   = SEQ_LOW;
            end
          end
          default:
          begin
            load_val_next[i] = {ZERO_BYTE, wbyte};
            load_next[i]     = 1'b1;
          end
        endcase
        if (load_next[i])
          null_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      for (int i = 0; i < N; i++)
      begin
        fmt_reg[i]       <= FMT_RST;
        mode_reg[i]      <= MODE_RST;
        bcd_reg[i]       <= 1'b0;
        snap_reg[i]      <= COUNT_RST;
        snap_held_reg[i] <= 1'b0;
        stat_reg[i]      <= ZERO_BYTE;
        stat_held_reg[i] <= 1'b0;
        rd_seq_reg[i]    <= SEQ_LOW;
        wr_seq_reg[i]    <= SEQ_LOW;
        wr_low_reg[i]    <= ZERO_BYTE;
        load_reg[i]      <= 1'b0;
        load_val_reg[i]  <= COUNT_RST;
        null_reg[i]      <= 1'b0;
      end
    end
    else
    begin
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
      fmt_reg       <= fmt_next;
      mode_reg      <= mode_next;
      bcd_reg       <= bcd_next;
      snap_reg      <= snap_next;
      snap_held_reg <= snap_held_next;
      stat_reg      <= stat_next;
      stat_held_reg <= stat_held_next;
      rd_seq_reg    <= rd_seq_next;
      wr_seq_reg    <= wr_seq_next;
      wr_low_reg    <= wr_low_next;
      load_reg      <= load_next;
      load_val_reg  <= load_val_next;
      null_reg      <= null_next;
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = pready_reg;
  assign PSLVERR = pslverr_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_ctrl_write_only: assert property (
    access_first && !PWRITE && sel_now == SEL_CTRL |=> PREADY && PSLVERR)
    else $error("control port read not refused");
  a_apb_one_wait: assert property (
    access_first |=> PREADY ##1 !PREADY)
    else $error("apb answer timing wrong");
  for (genvar g = 0; g < N; g++)
  begin : g_chk
    a_snap_capture: assert property (
      cap_cnt_vec[g] && !snap_held_reg[g]
      |=> snap_held_reg[g] && snap_reg[g] == $past(ce_count[g]))
      else $error("snapshot not captured");
    a_snap_hold: assert property (
      snap_held_reg[g] && !rd_vec[g] && !prog_vec[g]
      |=> snap_held_reg[g] && $stable(snap_reg[g]))
      else $error("held snapshot changed");
    a_stat_hold: assert property (
      stat_held_reg[g] && !rd_vec[g] && !prog_vec[g]
      |=> stat_held_reg[g] && $stable(stat_reg[g]))
      else $error("held status changed");
    a_stat_first: assert property (
      rd_vec[g] && stat_held_reg[g] |-> PRDATA == 32'(stat_reg[g])
      ##1 !stat_held_reg[g])
      else $error("status not read first");
    a_release_read: assert property (
      rd_vec[g] && !stat_held_reg[g] && snap_held_reg[g]
      && (fmt_reg[g] != FMT_WORD || rd_seq_reg[g] == SEQ_HIGH) |=> !snap_held_reg[g])
      else $error("snapshot not released");
    a_stat_layout: assert property (
      cap_st_vec[g] && !stat_held_reg[g]
      |=> stat_reg[g][ST_OUT] == $past(out_sync[g])
      && stat_reg[g][ST_NULL] == $past(null_reg[g]))
      else $error("status layout wrong");
    a_ce_runs: assert property (
      !load_reg[g] |=> ce_count[g] == $past(ce_count[g]) - CW'(1))
      else $error("counting element disturbed");
    a_mode_keep: assert property (
      !prog_vec[g] |=> $stable(mode_reg[g]) && $stable(fmt_reg[g]))
      else $error("mode changed without control word");
    a_seq_split: assert property (
      wr_vec[g] |=> $stable(rd_seq_reg[g]))
      else $error("write disturbed read sequence");
  end
endmodule
`default_nettype wire

//--- verification/itrl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module itrl_host_model (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // one transfer; callers may put other transfers between the two bytes of a counter
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e, output int t);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    q = prdata[7:0];
    e = pslverr;
    t = (pready === 1'b1) ? int'($time / 50) : -1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_interval_timer_readout_latch.sv
`timescale 1ns/1ps
`default_nettype none
module tb_interval_timer_readout_latch;
  import itrl_pkg::*;
`define CHK(n, x, y) begin checks_done++; if ((x) !== (y)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, x, y); end end
  logic        clk;
  logic        rst_n;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rng;
  logic [2:0]  cnt_out;
  logic [2:0]  md [3];
  int          fails, checks_done;
  localparam int RST_CYC = 10;

  itrl_readout_latch u_dut (
    .CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .COUNTER_OUT(cnt_out),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
  );
  itrl_host_model u_host (
    .clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [11:0] adr(input int i);
    return {2'b00, IDX_CNT0 + 8'(i), 2'b00};
  endfunction
  function automatic logic [15:0] ahead(input logic [15:0] v, input int dt);
    return v - 16'(dt);
  endfunction

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic op(input logic w, input logic [11:0] a, input logic [7:0] d,
                    output logic [7:0] q, output logic e, output int t);
    u_host.xfer(w, a, d, q, e, t);
    if (t < 0)
    begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic wr(input int i, input logic [7:0] d, output int t);
    logic [7:0] q;
    logic       e;
    op(1'b1, adr(i), d, q, e, t);
    `CHK("write refused", 1'b0, e)
  endtask
  task automatic rd(input int i, output logic [7:0] q);
    logic e;
    int   t;
    op(1'b0, adr(i), 8'h00, q, e, t);
    `CHK("read refused", 1'b0, e)
  endtask
  task automatic rd16(input int i, output logic [15:0] v);
    rd(i, v[7:0]);
    rd(i, v[15:8]);
  endtask

  initial
  begin
    logic [7:0]  b, lo;
    logic [15:0] v, v1, w16;
    logic        e;
    int          t, t1, tw, i;
    rst_n = 1'b0;
    cnt_out = 3'h0;
    rng = 32'h1C;
    fails = 0;
    checks_done = 0;
    repeat (RST_CYC) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      md[i] = 3'(xs() % 6);
      wr(3, {2'(i), FMT_WORD, md[i], 1'b0}, t);
    end
    // status of all three, second capture must be ignored
    cnt_out <= 3'h5;
    repeat (4) @(posedge clk);
    wr(3, 8'hEE, t);
    cnt_out <= 3'h2;
    repeat (4) @(posedge clk);
    wr(3, 8'hEE, t);
    for (i = 0; i < 3; i++)
    begin
      rd(i, b);
      `CHK("status", {i != 1, 1'b1, FMT_WORD, md[i], 1'b0}, b)
    end
    // count and status together; counter 0 interleaves a new count
    w16 = 16'(xs());
    wr(3, 8'hCE, t1);
    for (i = 0; i < 3; i++)
    begin
      rd(i, b);
      `CHK("status first", {i == 1, 1'b1, FMT_WORD, md[i], 1'b0}, b)
    end
    rd(0, lo);
    wr(0, w16[7:0], t);
    rd(0, b);
    wr(0, w16[15:8], tw);
    v1 = {b, lo};
    `CHK("snapshot value", 16'(RST_CYC - t1), v1)
    for (i = 1; i < 3; i++)
    begin
      rd16(i, v);
      `CHK("readback count", v1, v)
    end
    // latch twice before reading
    wr(3, 8'h40, t);
    repeat (xs() % 8) @(posedge clk);
    wr(3, 8'h40, i);
    rd16(1, v);
    `CHK("latch held", ahead(v1, t - t1), v)
    wr(3, 8'hD8, t);
    wr(3, 8'hD8, i);
    rd16(2, v);
    `CHK("readback held", ahead(v1, t - t1), v)
    wr(3, 8'h00, t);
    rd16(0, v);
    `CHK("loaded count", ahead(w16, t - tw - 2), v)
    wr(3, 8'hE2, t);
    rd(0, b);
    `CHK("null cleared", {1'b0, 1'b0, FMT_WORD, md[0], 1'b0}, b)
    // one-byte formats
    wr(3, {2'd2, FMT_LSB, md[2], 1'b0}, t);
    wr(3, 8'h80, t);
    rd(2, b);
    v = ahead(v1, t - t1);
    `CHK("low only", v[7:0], b)
    wr(3, {2'd2, FMT_MSB, md[2], 1'b0}, t);
    wr(3, 8'h80, t);
    rd(2, b);
    v = ahead(v1, t - t1);
    `CHK("high only", v[15:8], b)
    // random latches with another counter read between bytes
    repeat (8)
    begin
      cnt_out <= 3'(xs());
      repeat (xs() % 16) @(posedge clk);
      wr(3, 8'h40, t);
      rd(1, lo);
      rd(2, b);
      rd(1, b);
      `CHK("split read", ahead(v1, t - t1), {b, lo})
    end
    op(1'b0, adr(3), 8'h00, b, e, t);
    `CHK("control read refused", 1'b1, e)
    `CHK("control read data", 8'h00, b)
    op(1'b0, adr(4), 8'h00, b, e, t);
    `CHK("unmapped refused", 1'b1, e)
    `CHK("unmapped data", 8'h00, b)
    give_verdict();
  end
endmodule
`default_nettype wire
